// >>> rtl/tmc_pkg.sv
/*
 * Constants, register map and carrier types of the time-of-flight
 * measurement control block.
 * Assumes a 250 MHz system clock and a host that reaches the registers
 * over a two-wire serial link clocked by the host.
 */
package tmc_pkg;

	localparam logic [7:0] REG_PWR_CTRL = 8'h01;
	localparam logic [7:0] REG_IVL_VAL = 8'h11;
	localparam logic [7:0] REG_IVL_RNG = 8'h12;
	localparam logic [7:0] REG_MODE = 8'h13;
	localparam logic [7:0] REG_IRQ_CFG = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h60;
	localparam logic [7:0] REG_EMIT_RNG = 8'h90;
	localparam logic [7:0] REG_EMIT_FINE = 8'h91;
	localparam logic [7:0] REG_THR = 8'h93;
	localparam logic [7:0] REG_CMD = 8'hb0;

	localparam logic [7:0] CMD_SOFT_START = 8'h49;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hd7;
	localparam logic [7:0] CMD_SOFT_CLEAR = 8'hd1;

	localparam int PWR_DIS_BIT = 0;
	localparam int MODE_SINGLE_BIT = 0;
	localparam int IRQ_EN_BIT = 0;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BROWNOUT_BIT = 1;
	localparam logic [7:0] STAT_BROWNOUT_MASK = 8'h02;

	localparam logic [7:0] RST_PWR_CTRL = 8'h00;
	localparam logic [7:0] RST_IVL_VAL = 8'h00;
	localparam logic [7:0] RST_IVL_RNG = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_IRQ_CFG = 8'h00;
	localparam logic [7:0] RST_IRQ_STAT = 8'h02;
	localparam logic [7:0] RST_EMIT_RNG = 8'h00;
	localparam logic [7:0] RST_EMIT_FINE = 8'h00;
	localparam logic [7:0] RST_THR = 8'h00;

	localparam logic [19:0] EMIT_FULL_MA = 20'h000ff;
	localparam logic [19:0] EMIT_DIV = 20'h00ef1;
	localparam logic [7:0] THR_MAX_MA = 8'h1e;

	localparam int CLK_PERIOD_PS = 4000;
	localparam int TICK_TIME_US = 450;
	localparam int TICK_CYCLES = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;
	localparam int INTEG_TIME_US = 100;
	localparam int INTEG_CYCLES = INTEG_TIME_US * 1000000 / CLK_PERIOD_PS;

	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_INTEG = 2'b01,
		SEQ_WAIT = 2'b11
	} tmc_seq_t;

	typedef enum logic [2:0] {
		PH_ADDR = 3'b000,
		PH_PTR = 3'b001,
		PH_WDATA = 3'b011,
		PH_RDATA = 3'b010,
		PH_IGNORE = 3'b110
	} tmc_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} tmc_wr_t;

endpackage : tmc_pkg

// >>> rtl/tmc_top.sv
/*
 * Measurement control of the time-of-flight sensor: serial register
 * slave on the host clock, register file, measurement sequencer and
 * emitter current codes on the system clock.
 * Assumes the host clock stops only with the bus idle and that the
 * interrupt and data lines have pull-ups outside the block.
 */
`timescale 1ns/1ps
module tmc_top #(
	parameter int TICK_CYC = tmc_pkg::TICK_CYCLES,   // 450 us tick
	parameter int INTEG_CYC = tmc_pkg::INTEG_CYCLES, // Integration time
	parameter logic [6:0] DEV_ADDR = tmc_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic MCLK_I,                      // System clock
	input wire logic RSTN_I,                      // Async reset, low
	input wire logic SCL_I,                       // Host serial clock
	input wire logic SDA_I,                       // Serial data in
	output logic SDA_O,                           // Serial data out
	output logic SDA_OE_O,                        // Data pull-low enable
	input wire logic CHIP_ENABLE_N_I,             // Chip enable, low
	input wire logic SAMPLE_START_I,              // Sample-start pin
	output logic IRQ_O,                           // Interrupt level out
	output logic IRQ_OE_O,                        // Interrupt pull enable
	output logic BIAS_EN_O,                       // Internal bias on
	output logic EMITTER_DRIVE_PIN_O,             // Emitter pulsing
	output logic [7:0] EMITTER_PULSE_CURRENT_O,   // Pulse current, mA
	output logic [7:0] THRESHOLD_CURRENT_O        // DC current, mA
);
	import tmc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_ff;
	logic rst_n;

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Start detection, clocked by falling data
	logic start_tgl_ff;
	logic nxt_start_tgl;

	// Data falling while the clock is high marks a new frame
	always_comb begin
		nxt_start_tgl = SCL_I ? ~start_tgl_ff : start_tgl_ff;
	end

	always_ff @(negedge SDA_I or negedge rst_n) begin
		if (!rst_n)
			start_tgl_ff <= 1'b0;
		else
			start_tgl_ff <= nxt_start_tgl;
	end

	////////////////////////////////////////////////////////////////////
	// Serial slave, rising host clock
	logic start_seen_ff, nxt_start_seen;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] shift_ff, nxt_shift;
	tmc_phase_t phase_ff, nxt_phase;
	logic [7:0] ptr_ff, nxt_ptr;
	logic ack_ff, nxt_ack;
	tmc_wr_t wr_ff, nxt_wr;
	logic wr_tgl_ff, nxt_wr_tgl;
	logic [7:0] fetch_addr_ff, nxt_fetch_addr;
	logic fetch_tgl_ff, nxt_fetch_tgl;
	logic [7:0] cons_addr_ff, nxt_cons_addr;
	logic cons_tgl_ff, nxt_cons_tgl;
	logic [7:0] byte_w;

	always_comb begin
		byte_w = {shift_ff[6:0], SDA_I};
		nxt_start_seen = start_seen_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_phase = phase_ff;
		nxt_ptr = ptr_ff;
		nxt_ack = 1'b0;
		nxt_wr = wr_ff;
		nxt_wr_tgl = wr_tgl_ff;
		nxt_fetch_addr = fetch_addr_ff;
		nxt_fetch_tgl = fetch_tgl_ff;
		nxt_cons_addr = cons_addr_ff;
		nxt_cons_tgl = cons_tgl_ff;
		if (start_tgl_ff != start_seen_ff) begin
			nxt_start_seen = start_tgl_ff;
			nxt_bit_cnt = 4'h1;
			nxt_shift = {7'h00, SDA_I};
			nxt_phase = PH_ADDR;
		end else if (bit_cnt_ff != 4'h8) begin
			nxt_bit_cnt = bit_cnt_ff + 4'h1;
			nxt_shift = byte_w;
			if (bit_cnt_ff == 4'h0 && phase_ff == PH_RDATA) begin
				nxt_cons_addr = ptr_ff;
				nxt_cons_tgl = ~cons_tgl_ff;
				nxt_ptr = ptr_ff + 8'h01;
				nxt_fetch_addr = ptr_ff + 8'h01;
				nxt_fetch_tgl = ~fetch_tgl_ff;
			end
			if (bit_cnt_ff == 4'h7) begin
				case (phase_ff)
				PH_ADDR: begin
					if (byte_w[7:1] == DEV_ADDR) begin
						nxt_ack = 1'b1;
						nxt_phase = byte_w[0] ? PH_RDATA : PH_PTR;
						nxt_fetch_addr = ptr_ff;
						nxt_fetch_tgl = byte_w[0] ? ~fetch_tgl_ff
							: fetch_tgl_ff;
					end else begin
						nxt_phase = PH_IGNORE;
					end
				end
				PH_PTR: begin
					nxt_ack = 1'b1;
					nxt_ptr = byte_w;
					nxt_phase = PH_WDATA;
				end
				PH_WDATA: begin
					nxt_ack = 1'b1;
					nxt_wr = '{addr: ptr_ff, data: byte_w};
					nxt_wr_tgl = ~wr_tgl_ff;
					nxt_ptr = ptr_ff + 8'h01;
				end
				default: begin
				end
				endcase
			end
		end else begin
			nxt_bit_cnt = 4'h0;
			// Host not acknowledging ends the read burst
			if (phase_ff == PH_RDATA && SDA_I)
				nxt_phase = PH_IGNORE;
		end
	end

	always_ff @(posedge SCL_I or negedge rst_n) begin
		if (!rst_n) begin
			start_seen_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			phase_ff <= PH_IGNORE;
			ptr_ff <= 8'h00;
			ack_ff <= 1'b0;
			wr_ff <= '0;
			wr_tgl_ff <= 1'b0;
			fetch_addr_ff <= 8'h00;
			fetch_tgl_ff <= 1'b0;
			cons_addr_ff <= 8'h00;
			cons_tgl_ff <= 1'b0;
		end else begin
			start_seen_ff <= nxt_start_seen;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			phase_ff <= nxt_phase;
			ptr_ff <= nxt_ptr;
			ack_ff <= nxt_ack;
			wr_ff <= nxt_wr;
			wr_tgl_ff <= nxt_wr_tgl;
			fetch_addr_ff <= nxt_fetch_addr;
			fetch_tgl_ff <= nxt_fetch_tgl;
			cons_addr_ff <= nxt_cons_addr;
			cons_tgl_ff <= nxt_cons_tgl;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial driver, falling host clock
	logic sda_oe_ff, nxt_sda_oe;
	logic [7:0] obyte_ff, nxt_obyte;
	logic [7:0] rd_word_ff;
	logic [2:0] obit;

	// Read word settles a bit time before use; fetch ends in ns
	always_comb begin
		nxt_sda_oe = 1'b0;
		nxt_obyte = obyte_ff;
		obit = 3'(4'h7 - bit_cnt_ff);
		if (ack_ff) begin
			nxt_sda_oe = 1'b1;
		end else if (phase_ff == PH_RDATA) begin
			if (bit_cnt_ff == 4'h0) begin
				nxt_obyte = rd_word_ff;
				nxt_sda_oe = ~rd_word_ff[7];
			end else if (bit_cnt_ff != 4'h8) begin
				nxt_sda_oe = ~obyte_ff[obit];
			end
		end
	end

	always_ff @(negedge SCL_I or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_ff <= 1'b0;
			obyte_ff <= 8'h00;
		end else begin
			sda_oe_ff <= nxt_sda_oe;
			obyte_ff <= nxt_obyte;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Synchronisers into the system clock
	logic [4:0] sync_meta_ff, sync_ff;
	logic [3:0] sync_prev_ff;
	logic ce_n_s, ss_rise, wr_pulse, fetch_pulse, cons_pulse;

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta_ff <= 5'h01;
			sync_ff <= 5'h01;
			sync_prev_ff <= 4'h0;
		end else begin
			sync_meta_ff <= {cons_tgl_ff, fetch_tgl_ff, wr_tgl_ff,
				SAMPLE_START_I, CHIP_ENABLE_N_I};
			sync_ff <= sync_meta_ff;
			sync_prev_ff <= sync_ff[4:1];
		end
	end

	assign ce_n_s = sync_ff[0];
	assign ss_rise = sync_ff[1] & ~sync_prev_ff[0];
	assign wr_pulse = sync_ff[2] ^ sync_prev_ff[1];
	assign fetch_pulse = sync_ff[3] ^ sync_prev_ff[2];
	assign cons_pulse = sync_ff[4] ^ sync_prev_ff[3];

	////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0] pwr_ff, ivl_val_ff, ivl_rng_ff, mode_ff, irq_cfg_ff;
	logic [7:0] stat_ff, emit_rng_ff, emit_fine_ff, thr_ff, snap_ff;
	logic [7:0] nxt_pwr, nxt_ivl_val, nxt_ivl_rng, nxt_mode, nxt_irq_cfg;
	logic [7:0] nxt_stat, nxt_emit_rng, nxt_emit_fine, nxt_thr, nxt_snap;
	logic [7:0] nxt_rd_word, rd_mux, stat_clr, stat_set;
	logic is_cmd, cmd_start, cmd_reset, cmd_clear, done_set;

	assign is_cmd = wr_pulse && wr_ff.addr == REG_CMD;
	assign cmd_start = is_cmd && wr_ff.data == CMD_SOFT_START;
	assign cmd_reset = is_cmd && wr_ff.data == CMD_SOFT_RESET;
	assign cmd_clear = is_cmd && wr_ff.data == CMD_SOFT_CLEAR;

	always_comb begin
		case (fetch_addr_ff)
		REG_PWR_CTRL: rd_mux = pwr_ff;
		REG_IVL_VAL: rd_mux = ivl_val_ff;
		REG_IVL_RNG: rd_mux = ivl_rng_ff;
		REG_MODE: rd_mux = mode_ff;
		REG_IRQ_CFG: rd_mux = irq_cfg_ff;
		REG_IRQ_STAT: rd_mux = stat_ff;
		REG_EMIT_RNG: rd_mux = emit_rng_ff;
		REG_EMIT_FINE: rd_mux = emit_fine_ff;
		REG_THR: rd_mux = thr_ff;
		default: rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		nxt_pwr = pwr_ff;
		nxt_ivl_val = ivl_val_ff;
		nxt_ivl_rng = ivl_rng_ff;
		nxt_mode = mode_ff;
		nxt_irq_cfg = irq_cfg_ff;
		nxt_emit_rng = emit_rng_ff;
		nxt_emit_fine = emit_fine_ff;
		nxt_thr = thr_ff;
		nxt_rd_word = fetch_pulse ? rd_mux : rd_word_ff;
		nxt_snap = snap_ff;
		if (fetch_pulse && fetch_addr_ff == REG_IRQ_STAT)
			nxt_snap = stat_ff;
		// clear only what was shown; a new event survives
		stat_clr = (cons_pulse && cons_addr_ff == REG_IRQ_STAT)
			? snap_ff : 8'h00;
		stat_set = 8'h00;
		stat_set[STAT_DONE_BIT] = done_set;
		nxt_stat = (stat_ff & ~stat_clr) | stat_set;
		// disable bit written any time; enable keeps registers
		if (wr_pulse) begin
			case (wr_ff.addr)
			REG_PWR_CTRL: nxt_pwr = wr_ff.data;
			REG_IVL_VAL: nxt_ivl_val = wr_ff.data;
			REG_IVL_RNG: nxt_ivl_rng = wr_ff.data;
			REG_MODE: nxt_mode = wr_ff.data;
			REG_IRQ_CFG: nxt_irq_cfg = wr_ff.data;
			REG_EMIT_RNG: nxt_emit_rng = wr_ff.data;
			REG_EMIT_FINE: nxt_emit_fine = wr_ff.data;
			REG_THR: nxt_thr = wr_ff.data;
			default: begin
			end
			endcase
		end
		if (cmd_reset) begin
			nxt_pwr = RST_PWR_CTRL;
			nxt_ivl_val = RST_IVL_VAL;
			nxt_ivl_rng = RST_IVL_RNG;
			nxt_mode = RST_MODE;
			nxt_irq_cfg = RST_IRQ_CFG;
			nxt_emit_rng = RST_EMIT_RNG;
			nxt_emit_fine = RST_EMIT_FINE;
			nxt_thr = RST_THR;
			nxt_stat = (RST_IRQ_STAT & ~STAT_BROWNOUT_MASK)
				| (stat_ff & STAT_BROWNOUT_MASK);
		end
	end

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pwr_ff <= RST_PWR_CTRL;
			ivl_val_ff <= RST_IVL_VAL;
			ivl_rng_ff <= RST_IVL_RNG;
			mode_ff <= RST_MODE;
			irq_cfg_ff <= RST_IRQ_CFG;
			stat_ff <= RST_IRQ_STAT;
			emit_rng_ff <= RST_EMIT_RNG;
			emit_fine_ff <= RST_EMIT_FINE;
			thr_ff <= RST_THR;
			snap_ff <= 8'h00;
			rd_word_ff <= 8'h00;
		end else begin
			pwr_ff <= nxt_pwr;
			ivl_val_ff <= nxt_ivl_val;
			ivl_rng_ff <= nxt_ivl_rng;
			mode_ff <= nxt_mode;
			irq_cfg_ff <= nxt_irq_cfg;
			stat_ff <= nxt_stat;
			emit_rng_ff <= nxt_emit_rng;
			emit_fine_ff <= nxt_emit_fine;
			thr_ff <= nxt_thr;
			snap_ff <= nxt_snap;
			rd_word_ff <= nxt_rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Measurement sequencer
	tmc_seq_t seq_ff, nxt_seq;
	logic [23:0] integ_ff, nxt_integ;
	logic [23:0] tick_ff, nxt_tick;
	logic [23:0] units_ff, nxt_units, units_load;
	logic active, trigger, start;

	assign active = ~ce_n_s & ~pwr_ff[PWR_DIS_BIT];
	assign trigger = (ss_rise | cmd_start) & active;
	assign units_load = 24'h000001
		+ (24'(ivl_val_ff) << ivl_rng_ff[3:0]);

	always_comb begin
		nxt_seq = seq_ff;
		nxt_integ = integ_ff;
		nxt_tick = tick_ff;
		nxt_units = units_ff;
		done_set = 1'b0;
		start = 1'b0;
		if (seq_ff != SEQ_IDLE) begin
			if (tick_ff == 24'(TICK_CYC - 1)) begin
				nxt_tick = 24'h000000;
				if (units_ff != 24'h000000)
					nxt_units = units_ff - 24'h000001;
			end else begin
				nxt_tick = tick_ff + 24'h000001;
			end
		end
		case (seq_ff)
		SEQ_IDLE: start = trigger;
		SEQ_INTEG: begin
			if (integ_ff == 24'(INTEG_CYC - 1)) begin
				done_set = 1'b1;
				nxt_seq = mode_ff[MODE_SINGLE_BIT] ? SEQ_IDLE : SEQ_WAIT;
			end else begin
				nxt_integ = integ_ff + 24'h000001;
			end
		end
		// restart as the last tick ends, keeps the period exact
		SEQ_WAIT: start = units_ff == 24'h000000 || (units_ff == 24'h000001
			&& tick_ff == 24'(TICK_CYC - 1));
		default: nxt_seq = SEQ_IDLE;
		endcase
		if (start) begin
			nxt_seq = SEQ_INTEG;
			nxt_integ = 24'h000000;
			nxt_tick = 24'h000000;
			nxt_units = units_load;
		end
		// abort on clear, reset or shutdown
		if (!active || cmd_clear || cmd_reset) begin
			nxt_seq = SEQ_IDLE;
			nxt_integ = 24'h000000;
			nxt_tick = 24'h000000;
			nxt_units = 24'h000000;
			done_set = 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			seq_ff <= SEQ_IDLE;
			integ_ff <= 24'h000000;
			tick_ff <= 24'h000000;
			units_ff <= 24'h000000;
		end else begin
			seq_ff <= nxt_seq;
			integ_ff <= nxt_integ;
			tick_ff <= nxt_tick;
			units_ff <= nxt_units;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output registers
	logic irq_oe_ff, nxt_irq_oe, bias_ff, drive_ff, nxt_drive;
	logic [7:0] pulse_ff, nxt_pulse, dc_ff, nxt_dc;
	logic [19:0] emit_prod;

	assign emit_prod = 20'(emit_rng_ff[3:0]) * 20'(emit_fine_ff)
		* EMIT_FULL_MA;

	always_comb begin
		// pull low while completion pending and enabled
		nxt_irq_oe = irq_cfg_ff[IRQ_EN_BIT] & stat_ff[STAT_DONE_BIT];
		nxt_drive = nxt_seq == SEQ_INTEG;
		nxt_pulse = nxt_drive ? 8'(emit_prod / EMIT_DIV) : 8'h00;
		nxt_dc = 8'h00;
		if (nxt_drive)
			nxt_dc = (thr_ff > THR_MAX_MA) ? THR_MAX_MA : thr_ff;
	end

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			irq_oe_ff <= 1'b0;
			bias_ff <= 1'b0;
			drive_ff <= 1'b0;
			pulse_ff <= 8'h00;
			dc_ff <= 8'h00;
		end else begin
			irq_oe_ff <= nxt_irq_oe;
			bias_ff <= active;
			drive_ff <= nxt_drive;
			pulse_ff <= nxt_pulse;
			dc_ff <= nxt_dc;
		end
	end

	// Open-drain pins only ever pull low
	logic low_ff;

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n)
			low_ff <= 1'b0;
		else
			low_ff <= 1'b0;
	end

	assign SDA_O = low_ff;
	assign SDA_OE_O = sda_oe_ff;
	assign IRQ_O = low_ff;
	assign IRQ_OE_O = irq_oe_ff;
	assign BIAS_EN_O = bias_ff;
	assign EMITTER_DRIVE_PIN_O = drive_ff;
	assign EMITTER_PULSE_CURRENT_O = pulse_ff;
	assign THRESHOLD_CURRENT_O = dc_ff;

endmodule : tmc_top

// >>> sim/tmc_top_properties.sv
/*
 * Port-level checks of tmc_top, bound into every instance of it.
 * Assumes the serial and interrupt lines have pull-ups outside.
 */
`timescale 1ns/1ps
module tmc_top_properties #(
	parameter int INTEG_CYC = 8
) (
	input wire logic MCLK_I,                    // System clock
	input wire logic RSTN_I,                    // Reset, low
	input wire logic SCL_I,                     // Serial clock
	input wire logic CHIP_ENABLE_N_I,           // Enable pin, low
	input wire logic SDA_O,                     // Data level
	input wire logic IRQ_O,                     // Interrupt level
	input wire logic IRQ_OE_O,                  // Interrupt pull
	input wire logic BIAS_EN_O,                 // Bias on
	input wire logic EMITTER_DRIVE_PIN_O,       // Integrating
	input wire logic [7:0] EMITTER_PULSE_CURRENT_O, // Pulse mA
	input wire logic [7:0] THRESHOLD_CURRENT_O  // DC mA
);
	import tmc_pkg::*;
	logic scl_d_ff, drv_d_ff;
	logic [5:0] idle_ff, nxt_idle;
	logic [15:0] len_ff, nxt_len;
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RSTN_I);
	////////////////////////////////////////////////////////////////
	// bus idle time, integration length
	always_comb begin
		nxt_idle = idle_ff;
		if (SCL_I != scl_d_ff) begin
			nxt_idle = 6'h00;
		end else if (idle_ff != 6'h3f) begin
			nxt_idle = idle_ff + 6'h01;
		end
		nxt_len = len_ff;
		if (EMITTER_DRIVE_PIN_O) begin
			nxt_len = drv_d_ff ? len_ff + 16'h0001 : 16'h0001;
		end
	end
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			scl_d_ff <= 1'b1;
			drv_d_ff <= 1'b0;
			idle_ff <= 6'h3f;
			len_ff <= 16'h0000;
		end else begin
			scl_d_ff <= SCL_I;
			drv_d_ff <= EMITTER_DRIVE_PIN_O;
			idle_ff <= nxt_idle;
			len_ff <= nxt_len;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_open_drain; !IRQ_O && !SDA_O; endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain level driven high");
	property p_thr_max; THRESHOLD_CURRENT_O <= THR_MAX_MA; endproperty
	a_thr_max: assert property (p_thr_max)
		else $error("threshold current above limit");
	property p_dc_window;
		!EMITTER_DRIVE_PIN_O |->
			THRESHOLD_CURRENT_O == 8'h00 && EMITTER_PULSE_CURRENT_O == 8'h00;
	endproperty
	a_dc_window: assert property (p_dc_window)
		else $error("emitter current outside integration");
	property p_pin_off; CHIP_ENABLE_N_I [*5] |-> !BIAS_EN_O; endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("bias on with enable pin high");
	property p_start_on; $rose(EMITTER_DRIVE_PIN_O) |-> BIAS_EN_O; endproperty
	a_start_on: assert property (p_start_on)
		else $error("measurement started while disabled");
	property p_stop_sense;
		$fell(BIAS_EN_O) |-> ##[0:3] !EMITTER_DRIVE_PIN_O [*4];
	endproperty
	a_stop_sense: assert property (p_stop_sense)
		else $error("sensing goes on after disable");
	property p_done_len;
		$rose(IRQ_OE_O) |->
			len_ff == 16'(INTEG_CYC) && !EMITTER_DRIVE_PIN_O;
	endproperty
	a_done_len: assert property (p_done_len)
		else $error("interrupt without a full integration");
	property p_irq_clear; $fell(IRQ_OE_O) |-> idle_ff < 6'h10; endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt cleared with the bus idle");
endmodule : tmc_top_properties

bind tmc_top tmc_top_properties #(.INTEG_CYC(INTEG_CYC)) u_props (
	.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .SCL_I(SCL_I),
	.CHIP_ENABLE_N_I(CHIP_ENABLE_N_I), .SDA_O(SDA_O), .IRQ_O(IRQ_O),
	.IRQ_OE_O(IRQ_OE_O), .BIAS_EN_O(BIAS_EN_O),
	.EMITTER_DRIVE_PIN_O(EMITTER_DRIVE_PIN_O),
	.EMITTER_PULSE_CURRENT_O(EMITTER_PULSE_CURRENT_O),
	.THRESHOLD_CURRENT_O(THRESHOLD_CURRENT_O));

// >>> sim/tmc_host_model.sv
/*
 * Host model: serial register master, clock idles high between frames.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/1ps
module tmc_host_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	output logic scl_o,    // Serial clock
	output logic pull_o,   // Pulls data low
	input wire logic sda_i // Data level
);
	logic ack_ok = 1'b1;
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// Data only moves while the clock is low
	task automatic bitx(input logic b, output logic r);
		pull_o = !b;
		#12 scl_o = 1'b1;
		#12 r = sda_i;
		#12 scl_o = 1'b0;
		#12;
	endtask : bitx
	// Odd offset keeps the link out of step with the system clock
	task automatic start();
		#1.3 pull_o = 1'b0;
		#12 scl_o = 1'b1;
		#12 pull_o = 1'b1;
		#12 scl_o = 1'b0;
		#12;
	endtask : start
	task automatic stop();
		pull_o = 1'b1;
		#12 scl_o = 1'b1;
		#12 pull_o = 1'b0;
		#24;
	endtask : stop
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack_ok = ack_ok & !r;
	endtask : tx
	task automatic wr(input logic [6:0] a, input logic [7:0] p, v);
		ack_ok = 1'b1;
		start();
		tx({a, 1'b0});
		tx(p);
		tx(v);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic r;
		ack_ok = 1'b1;
		start();
		tx({ADDR, 1'b0});
		tx(p);
		start();
		tx({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(1'b1, r);
		stop();
	endtask : rd
endmodule : tmc_host_model

// >>> sim/test_tmc_top.sv
/*
 * Self-checking bench of tmc_top with the host model on the link.
 * Assumes pins change on the falling system clock edge.
 */
`timescale 1ns/1ps
module test_tmc_top;
	import tmc_pkg::*;
	localparam int TICK = 20;
	localparam int INTEG = 8;
	logic mclk, rstn, scl, pull, sda, ce_n, ss;
	logic sda_o, sda_oe, irq_o, irq_oe, bias, drive;
	logic [7:0] pulse, thr, rg, fine, iv, ir, got;
	logic [7:0] cfg[5] = '{REG_IVL_VAL, REG_IVL_RNG, REG_EMIT_RNG,
		REG_EMIT_FINE, REG_THR};
	logic [7:0] bad[4] = '{8'h00, 8'h48, 8'hd0, 8'hff};
	logic [7:0] val[5];
	logic [7:0] exp_q[$];
	event got_ev;
	int failures = 0;
	int checked = 0;
	int seed = 36200;
	int nrise = 0;
	int ncyc = 0;
	int n0, e;
	int rise_t[$];
	assign sda = !(pull || sda_oe);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	tmc_top #(.TICK_CYC(TICK), .INTEG_CYC(INTEG),
		.DEV_ADDR(DEV_ADDR_DEFAULT)) dut (
		.MCLK_I(mclk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE_O(sda_oe), .CHIP_ENABLE_N_I(ce_n),
		.SAMPLE_START_I(ss), .IRQ_O(irq_o), .IRQ_OE_O(irq_oe),
		.BIAS_EN_O(bias), .EMITTER_DRIVE_PIN_O(drive),
		.EMITTER_PULSE_CURRENT_O(pulse), .THRESHOLD_CURRENT_O(thr));
	tmc_host_model #(.ADDR(DEV_ADDR_DEFAULT)) host (
		.scl_o(scl), .pull_o(pull), .sda_i(sda));
	always @(posedge mclk) ncyc++;
	always @(posedge drive) begin
		nrise++;
		rise_t.push_back(ncyc);
	end
	always @(got_ev) begin
		checked++;
		if (got !== exp_q[0]) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp_q[0]);
		end
		void'(exp_q.pop_front());
	end
	////////////////////////////////////////////////////////////////
	task automatic see(input logic [7:0] g, input logic [7:0] x);
		exp_q.push_back(x);
		got = g;
		->got_ev;
		#1;
	endtask : see
	task automatic rchk(input logic [7:0] r, input logic [7:0] x);
		logic [7:0] v;
		host.rd(r, v);
		see(v, x);
	endtask : rchk
	task automatic wr(input logic [7:0] r, input logic [7:0] v);
		host.wr(DEV_ADDR_DEFAULT, r, v);
	endtask : wr
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	task automatic pulse_ss();
		@(negedge mclk);
		ss = 1'b1;
		cyc(3);
		ss = 1'b0;
	endtask : pulse_ss
	task automatic wait_hi(ref logic s);
		for (int n = 0; n < 400 && s !== 1'b1; n++) cyc(1);
	endtask : wait_hi
	task automatic chk_cfg();
		foreach (cfg[i]) rchk(cfg[i], val[i]);
	endtask : chk_cfg
	task automatic end_sim();
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	initial begin
		rstn = 1'b0;
		ce_n = 1'b0;
		ss = 1'b0;
		cyc(6);
		rstn = 1'b1;
		cyc(6);
		wr(REG_EMIT_RNG, 8'h05);
		wr(REG_CMD, CMD_SOFT_RESET);
		rchk(REG_EMIT_RNG, RST_EMIT_RNG);
		rchk(REG_IRQ_STAT, RST_IRQ_STAT);
		rchk(REG_IRQ_STAT, 8'h00);
		// Brownout now clear: soft reset must not bring it back
		wr(REG_CMD, CMD_SOFT_RESET);
		rchk(REG_IRQ_STAT, 8'h00);
		rchk(REG_PWR_CTRL, RST_PWR_CTRL);
		rchk(REG_MODE, RST_MODE);
		rchk(8'h55, 8'h00);
		see({7'h0, host.ack_ok}, 8'h01);
		foreach (cfg[i]) begin
			val[i] = 8'($random(seed));
			wr(cfg[i], val[i]);
		end
		// Link stays usable while the chip is off
		@(negedge mclk);
		ce_n = 1'b1;
		cyc(6);
		see({7'h0, bias}, 8'h00);
		chk_cfg();
		@(negedge mclk);
		ce_n = 1'b0;
		wr(REG_PWR_CTRL, 8'h01);
		cyc(6);
		see({7'h0, bias}, 8'h00);
		n0 = nrise;
		pulse_ss();
		cyc(20);
		see(8'(nrise - n0), 8'h00);
		wr(REG_PWR_CTRL, 8'h00);
		cyc(6);
		see({7'h0, bias}, 8'h01);
		chk_cfg();
		rg = 8'($random(seed));
		fine = 8'($random(seed));
		wr(REG_MODE, 8'h01);
		wr(REG_IRQ_CFG, 8'h01);
		wr(REG_EMIT_RNG, rg);
		wr(REG_EMIT_FINE, fine);
		wr(REG_THR, 8'h28);
		n0 = nrise;
		pulse_ss();
		wait_hi(drive);
		see(pulse, 8'(rg[3:0] * fine * 255 / 3825));
		see(thr, THR_MAX_MA);
		pulse_ss();
		wait_hi(irq_oe);
		see({7'h0, irq_oe}, 8'h01);
		rchk(REG_IRQ_STAT, 8'h01);
		see({7'h0, irq_oe}, 8'h00);
		cyc(60);
		see(8'(nrise - n0), 8'h01);
		wr(REG_CMD, CMD_SOFT_START);
		wait_hi(irq_oe);
		see(8'(nrise - n0), 8'h02);
		rchk(REG_IRQ_STAT, 8'h01);
		foreach (bad[i]) wr(REG_CMD, bad[i]);
		cyc(40);
		see(8'(nrise - n0), 8'h02);
		rchk(REG_MODE, 8'h01);
		host.wr(DEV_ADDR_DEFAULT ^ 7'h01, REG_THR, 8'h11);
		see({7'h0, host.ack_ok}, 8'h00);
		rchk(REG_THR, 8'h28);
		iv = 8'(1 + ($random(seed) & 3));
		ir = 8'($random(seed) & 1);
		e = (1 + (iv << ir[3:0])) * TICK;
		wr(REG_IVL_VAL, iv);
		wr(REG_IVL_RNG, ir);
		wr(REG_MODE, 8'h00);
		n0 = rise_t.size();
		pulse_ss();
		for (int n = 0; n < 2000 && rise_t.size() < n0 + 3; n++) cyc(1);
		see(8'(rise_t[n0 + 1] - rise_t[n0]), 8'(e));
		see(8'(rise_t[n0 + 2] - rise_t[n0 + 1]), 8'(e));
		rchk(REG_IRQ_STAT, 8'h01);
		wait_hi(irq_oe);
		see({7'h0, irq_oe}, 8'h01);
		wr(REG_CMD, CMD_SOFT_CLEAR);
		n0 = nrise;
		cyc(400);
		see(8'(nrise - n0), 8'h00);
		rchk(REG_IVL_VAL, iv);
		end_sim();
	end
endmodule : test_tmc_top
